//--- rtl/aese_defines.vh
// register indices, field positions, reset values and timing of the cipher
`ifndef AESE_DEFINES_VH
`define AESE_DEFINES_VH
// register indices; byte address is four times the index
`define AESE_IDX_CTRL 14'h0540
`define AESE_IDX_IRQ_STAT 14'h0541
`define AESE_IDX_IRQ_MASK 14'h0542
`define AESE_IDX_WIN_LO 14'h0548
`define AESE_IDX_WIN_HI 14'h054B
`define AESE_IDX_KEY_LO 14'h0550
`define AESE_IDX_KEY_HI 14'h055F
// control/status fields
`define AESE_CTRL_DEC 0
`define AESE_CTRL_NEED_IN 1
`define AESE_CTRL_OUT_RDY 2
`define AESE_CTRL_CCM 7
`define AESE_CTRL_RESET 8'h02
// interrupt status fields
`define AESE_IRQ_DONE 0
`define AESE_IRQ_TAKEN 1
`define AESE_IRQ_W 2
// timing: rounds, and the longest block time in cycles
`define AESE_ROUNDS 4'hA
`define AESE_MAX_CYCLES 1000
`endif

//--- rtl/aese_engine.v
// aes-128 block engine with apb registers, dma word port and interrupt
//
// Behaviour
// - control bit 0 picks direction: one decrypts, zero encrypts
// - result sits in the data window and is taken by four reads
// - input-request flag clears itself on the fourth data write
// - output-ready sets at block end, clears on the fourth data read
// - a block finishes well within 1000 clocks of its last input word
// - chaining off: each result depends on current block and key only
// - control bit 7 chains each block with the previous result
// - control register resets to 0x02: input needed, output not ready
`timescale 1ns/1ps
`include "aese_defines.vh"
module aese_engine (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    output wire irq,
    input wire dma_wr_en,
    input wire [31:0] dma_wr_data,
    input wire dma_rd_en,
    output wire [31:0] dma_rd_data,
    output wire dma_in_req,
    output wire dma_out_req
);

// =====================================================================
// galois field helpers and aes transforms
// =====================================================================
function [7:0] xt;
    input [7:0] b;
    begin
        xt = {b[6:0], 1'b0} ^ (b[7] ? 8'h1B : 8'h00);
    end
endfunction

function [7:0] gmul;
    input [7:0] a;
    input [7:0] b;
    integer i;
    reg [7:0] p;
    reg [7:0] t;
    begin
        p = 8'h00;
        t = a;
        for (i = 0; i < 8; i = i + 1)
        begin
            if (b[i])
                p = p ^ t;
            t = xt(t);
        end
        gmul = p;
    end
endfunction

// multiplicative inverse as x^254; zero maps to zero
function [7:0] ginv;
    input [7:0] x;
    integer i;
    reg [7:0] r;
    reg [7:0] s;
    begin
        r = 8'h01;
        s = x;
        for (i = 1; i < 8; i = i + 1)
        begin
            s = gmul(s, s);
            r = gmul(r, s);
        end
        ginv = r;
    end
endfunction

function [7:0] rotl;
    input [7:0] x;
    input [2:0] n;
    begin
        rotl = (x << n) | (x >> (4'h8 - {1'b0, n}));
    end
endfunction

// computed s-box: trades area for a table-free description
function [7:0] sbox;
    input [7:0] x;
    reg [7:0] r;
    begin
        r = ginv(x);
        sbox = r ^ rotl(r, 3'd1) ^ rotl(r, 3'd2) ^ rotl(r, 3'd3)
            ^ rotl(r, 3'd4) ^ 8'h63;
    end
endfunction

function [7:0] isbox;
    input [7:0] y;
    begin
        isbox = ginv(rotl(y, 3'd1) ^ rotl(y, 3'd3) ^ rotl(y, 3'd6) ^ 8'h05);
    end
endfunction

function [7:0] rcon;
    input [3:0] n;
    begin
        case (n)
            4'h1: rcon = 8'h01;
            4'h2: rcon = 8'h02;
            4'h3: rcon = 8'h04;
            4'h4: rcon = 8'h08;
            4'h5: rcon = 8'h10;
            4'h6: rcon = 8'h20;
            4'h7: rcon = 8'h40;
            4'h8: rcon = 8'h80;
            4'h9: rcon = 8'h1B;
            4'hA: rcon = 8'h36;
            default: rcon = 8'h00;
        endcase
    end
endfunction

function [31:0] kg;
    input [31:0] w;
    input [3:0] n;
    begin
        kg = {sbox(w[23:16]) ^ rcon(n), sbox(w[15:8]), sbox(w[7:0]),
            sbox(w[31:24])};
    end
endfunction

function [127:0] knext;
    input [127:0] k;
    input [3:0] n;
    reg [31:0] w0;
    reg [31:0] w1;
    reg [31:0] w2;
    reg [31:0] w3;
    begin
        w0 = k[127:96] ^ kg(k[31:0], n);
        w1 = k[95:64] ^ w0;
        w2 = k[63:32] ^ w1;
        w3 = k[31:0] ^ w2;
        knext = {w0, w1, w2, w3};
    end
endfunction

function [127:0] kprev;
    input [127:0] k;
    input [3:0] n;
    reg [31:0] w3;
    begin
        w3 = k[31:0] ^ k[63:32];
        kprev = {k[127:96] ^ kg(w3, n), k[95:64] ^ k[127:96],
            k[63:32] ^ k[95:64], w3};
    end
endfunction

// byte (row r, column c) sits at index r + 4c, byte 0 in the top bits
function [127:0] enc_round;
    input [127:0] s;
    input [127:0] rk;
    input last;
    integer r;
    integer c;
    reg [7:0] b [0:15];
    reg [127:0] o;
    begin
        o = 128'h0;
        for (c = 0; c < 4; c = c + 1)
            for (r = 0; r < 4; r = r + 1)
                b[r + 4 * c] = sbox(s[127 - 8 * (r + 4 * ((c + r) % 4)) -: 8]);
        for (c = 0; c < 4; c = c + 1)
            for (r = 0; r < 4; r = r + 1)
                o[127 - 8 * (r + 4 * c) -: 8] = last ? b[r + 4 * c] :
                    xt(b[r + 4 * c]) ^ xt(b[(r + 1) % 4 + 4 * c])
                    ^ b[(r + 1) % 4 + 4 * c] ^ b[(r + 2) % 4 + 4 * c]
                    ^ b[(r + 3) % 4 + 4 * c];
        enc_round = o ^ rk;
    end
endfunction

function [127:0] dec_round;
    input [127:0] s;
    input [127:0] rk;
    input last;
    integer r;
    integer c;
    reg [7:0] b [0:15];
    reg [127:0] o;
    begin
        o = 128'h0;
        for (c = 0; c < 4; c = c + 1)
            for (r = 0; r < 4; r = r + 1)
                b[r + 4 * c] = isbox(s[127 - 8
                    * (r + 4 * ((c + 4 - r) % 4)) -: 8])
                    ^ rk[127 - 8 * (r + 4 * c) -: 8];
        for (c = 0; c < 4; c = c + 1)
            for (r = 0; r < 4; r = r + 1)
                o[127 - 8 * (r + 4 * c) -: 8] = last ? b[r + 4 * c] :
                    gmul(b[r + 4 * c], 8'h0E)
                    ^ gmul(b[(r + 1) % 4 + 4 * c], 8'h0B)
                    ^ gmul(b[(r + 2) % 4 + 4 * c], 8'h0D)
                    ^ gmul(b[(r + 3) % 4 + 4 * c], 8'h09);
        dec_round = o;
    end
endfunction

// =====================================================================
// apb decode and register state
// =====================================================================
localparam ST_IDLE = 2'd0;
localparam ST_KEXP = 2'd1;
localparam ST_RUN = 2'd2;

wire [13:0] idx = paddr[15:2];
wire setup = psel && !penable;
wire acc = psel && penable;
wire hit_ctrl = idx == `AESE_IDX_CTRL;
wire hit_stat = idx == `AESE_IDX_IRQ_STAT;
wire hit_mask = idx == `AESE_IDX_IRQ_MASK;
wire hit_win = idx >= `AESE_IDX_WIN_LO && idx <= `AESE_IDX_WIN_HI;
wire hit_key = idx >= `AESE_IDX_KEY_LO && idx <= `AESE_IDX_KEY_HI;
wire mapped = (paddr[1:0] == 2'b00)
    && (hit_ctrl || hit_stat || hit_mask || hit_win || hit_key);

reg dec_q;
reg ccm_q;
reg need_in_q;
reg out_rdy_q;
reg [1:0] wcnt_q;
reg [1:0] rcnt_q;
reg [127:0] key_q;
reg [127:0] in_q;
reg [127:0] res_q;
reg [127:0] chain_q;
reg [127:0] st_q;
reg [127:0] rk_q;
reg [3:0] rnd_q;
reg [1:0] state_q;
reg run_dec_q;
reg [`AESE_IRQ_W-1:0] stat_q;
reg [`AESE_IRQ_W-1:0] mask_q;

// window words come from apb first, dma only when apb is not writing
wire apb_win_wr = acc && pwrite && hit_win && paddr[1:0] == 2'b00;
wire apb_win_rd = acc && !pwrite && hit_win && paddr[1:0] == 2'b00;
wire win_wr = (apb_win_wr || dma_wr_en) && need_in_q;
wire win_rd = (apb_win_rd || dma_rd_en) && out_rdy_q;
wire [31:0] win_wdata = apb_win_wr ? pwdata : dma_wr_data;
wire last_wr = win_wr && wcnt_q == 2'd3;
wire last_rd = win_rd && rcnt_q == 2'd3;
wire [31:0] res_word = res_q[32 * rcnt_q +: 32];
wire [127:0] blk_in = {win_wdata, in_q[95:0]};
wire [127:0] chain_in = ccm_q ? chain_q : 128'h0;
wire [127:0] rk_step = run_dec_q ? kprev(rk_q, rnd_q) : knext(rk_q, rnd_q);
wire finish = state_q == ST_RUN
    && (run_dec_q ? rnd_q == 4'h1 : rnd_q == `AESE_ROUNDS);
wire [127:0] round_out = run_dec_q
    ? dec_round(st_q, rk_step, rnd_q == 4'h1)
    : enc_round(st_q, rk_step, rnd_q == `AESE_ROUNDS);
wire [127:0] result = run_dec_q ? round_out ^ chain_in : round_out;

assign pready = 1'b1;
assign dma_rd_data = res_word;
assign dma_in_req = need_in_q;
assign dma_out_req = out_rdy_q;
assign irq = |(stat_q & mask_q);

// =====================================================================
// read data is prepared in the setup cycle so it comes from a flop
// =====================================================================
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prdata <= 32'h0;
        pslverr <= 1'b0;
    end
    else if (setup)
    begin
        pslverr <= !mapped;
        prdata <= 32'h0;
        if (mapped && hit_ctrl)
            prdata <= {24'h0, ccm_q, 4'h0, out_rdy_q, need_in_q, dec_q};
        else if (mapped && hit_stat)
            prdata <= {{(32-`AESE_IRQ_W){1'b0}}, stat_q};
        else if (mapped && hit_mask)
            prdata <= {{(32-`AESE_IRQ_W){1'b0}}, mask_q};
        else if (mapped && hit_win && out_rdy_q)
            prdata <= res_word;
        else if (mapped && hit_key)
            prdata <= {24'h0, key_q[8 * (15 - idx[3:0]) +: 8]};
    end
end

// =====================================================================
// software registers, window counters and interrupt status
// =====================================================================
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        dec_q <= 1'b0;
        ccm_q <= 1'b0;
        need_in_q <= 1'b1;
        out_rdy_q <= 1'b0;
        wcnt_q <= 2'd0;
        rcnt_q <= 2'd0;
        key_q <= 128'h0;
        in_q <= 128'h0;
        stat_q <= {`AESE_IRQ_W{1'b0}};
        mask_q <= {`AESE_IRQ_W{1'b0}};
    end
    else
    begin
        // flags bits 1 and 2 are not writable
        if (acc && pwrite && mapped && hit_ctrl)
        begin
            dec_q <= pwdata[`AESE_CTRL_DEC];
            ccm_q <= pwdata[`AESE_CTRL_CCM];
        end
        if (acc && pwrite && mapped && hit_mask)
            mask_q <= pwdata[`AESE_IRQ_W-1:0];
        if (acc && pwrite && mapped && hit_key)
            key_q[8 * (15 - idx[3:0]) +: 8] <= pwdata[7:0];
        if (win_wr)
        begin
            in_q[32 * wcnt_q +: 32] <= win_wdata;
            wcnt_q <= wcnt_q + 2'd1;
        end
        if (last_wr)
            need_in_q <= 1'b0;
        if (win_rd)
            rcnt_q <= rcnt_q + 2'd1;
        // next block may be loaded once the result is drained
        if (last_rd)
        begin
            out_rdy_q <= 1'b0;
            need_in_q <= 1'b1;
        end
        if (finish)
            out_rdy_q <= 1'b1;
        // write-one-to-clear; a same-cycle event keeps its bit set
        stat_q <= (stat_q & ~((acc && pwrite && mapped && hit_stat)
            ? pwdata[`AESE_IRQ_W-1:0] : {`AESE_IRQ_W{1'b0}}))
            | {last_wr, finish};
    end
end

// =====================================================================
// round engine: one round per clock, keys expanded on the fly
// =====================================================================
// decryption walks the schedule forward first, then back down
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state_q <= ST_IDLE;
        st_q <= 128'h0;
        rk_q <= 128'h0;
        rnd_q <= 4'h0;
        run_dec_q <= 1'b0;
        res_q <= 128'h0;
        chain_q <= 128'h0;
    end
    else
    begin
        if (!ccm_q)
            chain_q <= 128'h0;
        case (state_q)
            ST_IDLE:
            begin
                if (last_wr)
                begin
                    run_dec_q <= dec_q;
                    rk_q <= key_q;
                    rnd_q <= 4'h1;
                    if (dec_q)
                    begin
                        st_q <= blk_in;
                        state_q <= ST_KEXP;
                    end
                    else
                    begin
                        st_q <= blk_in ^ chain_in ^ key_q;
                        state_q <= ST_RUN;
                    end
                end
            end
            ST_KEXP:
            begin
                rk_q <= knext(rk_q, rnd_q);
                if (rnd_q == `AESE_ROUNDS)
                begin
                    st_q <= st_q ^ knext(rk_q, rnd_q);
                    state_q <= ST_RUN;
                end
                else
                    rnd_q <= rnd_q + 4'h1;
            end
            ST_RUN:
            begin
                st_q <= round_out;
                rk_q <= rk_step;
                rnd_q <= run_dec_q ? rnd_q - 4'h1 : rnd_q + 4'h1;
                if (finish)
                begin
                    res_q <= result;
                    if (ccm_q)
                        chain_q <= result;
                    state_q <= ST_IDLE;
                end
            end
            default:
                state_q <= ST_IDLE;
        endcase
    end
end

endmodule

//--- bench/aese_asserts.sv
// port-level concurrent checks for the cipher engine
`timescale 1ns/1ps
module aese_asserts (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire irq,
    input wire dma_wr_en,
    input wire [31:0] dma_wr_data,
    input wire dma_rd_en,
    input wire [31:0] dma_rd_data,
    input wire dma_in_req,
    input wire dma_out_req
);
    // ==========================================
    // window access decode, any of the four words
    wire acc = psel && penable;
    wire wwr = acc && pwrite && paddr[15:4] == 12'h152 && paddr[1:0] == 2'h0;
    wire wrd = acc && !pwrite && paddr[15:4] == 12'h152 && paddr[1:0] == 2'h0;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================
    // checks
    zero_wait_a: assert property (pready) else $error("pready low");
    flag_excl_a: assert property (!(dma_in_req && dma_out_req))
        else $error("both flags high");
    in_clear_a: assert property (
        $fell(dma_in_req) |-> $past(wwr || dma_wr_en))
        else $error("input flag cleared without a window write");
    block_time_a: assert property (
        $fell(dma_in_req) |-> ##[10:20] $rose(dma_out_req))
        else $error("block result late");
    out_clear_a: assert property (
        $fell(dma_out_req) |-> $rose(dma_in_req))
        else $error("input flag not rearmed with output clear");
    busy_hold_a: assert property (
        !dma_in_req && !dma_out_req |=> !dma_in_req)
        else $error("input flag rose while busy");
    out_hold_a: assert property (
        dma_out_req && !dma_rd_en && !wrd |=>
        dma_out_req && $stable(dma_rd_data))
        else $error("result moved without a read");
    misalign_err_a: assert property (
        psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned access not refused");
endmodule

bind aese_engine aese_asserts u_asserts (.*);

//--- bench/aese_dma_model.sv
// dma controller model: pushes one block in, pulls the result out
`timescale 1ns/1ps
module aese_dma_model (
    input wire pclk,
    input wire go,
    input wire [127:0] blk,
    input wire dma_in_req,
    input wire dma_out_req,
    input wire [31:0] dma_rd_data,
    output logic dma_wr_en,
    output logic [31:0] dma_wr_data,
    output logic dma_rd_en,
    output logic [127:0] result,
    output logic done
);
    integer i;
    // ==========================================
    // a single block once go is seen; a gap cycle after each pulse keeps counts clean
    initial
    begin
        dma_wr_en = 1'b0;
        dma_rd_en = 1'b0;
        dma_wr_data = 32'h0;
        result = 128'h0;
        done = 1'b0;
        while (!(go && dma_in_req)) @(posedge pclk);
        for (i = 0; i < 4; i++)
        begin
            dma_wr_en <= 1'b1;
            dma_wr_data <= blk[32*i +: 32];
            @(posedge pclk);
            dma_wr_en <= 1'b0;
            // released data shows the inverse, never the last word
            dma_wr_data <= ~blk[32*i +: 32];
            @(posedge pclk);
        end
        while (!dma_out_req) @(posedge pclk);
        for (i = 0; i < 4; i++)
        begin
            dma_rd_en <= 1'b1;
            @(posedge pclk);
            result[32*i +: 32] = dma_rd_data;
            dma_rd_en <= 1'b0;
            @(posedge pclk);
        end
        done <= 1'b1;
    end
endmodule

//--- bench/aese_engine_tb.sv
// self-checking bench for the cipher engine over apb and dma
`timescale 1ns/1ps
`include "aese_defines.vh"
module aese_engine_tb;
    localparam logic [15:0] A_CTRL = {`AESE_IDX_CTRL, 2'b00};
    localparam logic [15:0] A_STAT = {`AESE_IDX_IRQ_STAT, 2'b00};
    localparam logic [15:0] A_MASK = {`AESE_IDX_IRQ_MASK, 2'b00};
    localparam logic [15:0] A_WIN = {`AESE_IDX_WIN_LO, 2'b00};
    localparam logic [15:0] A_KEY = {`AESE_IDX_KEY_LO, 2'b00};
    // standard aes-128 vector, byte 0 in the top bits
    localparam logic [127:0] K = 128'h000102030405060708090A0B0C0D0E0F;
    localparam logic [127:0] P = 128'h00112233445566778899AABBCCDDEEFF;
    localparam logic [127:0] C = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, irq, go = 1'b0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, dma_wr_data, dma_rd_data;
    logic dma_wr_en, dma_rd_en, dma_in_req, dma_out_req, done, er;
    logic [127:0] result;
    integer num_errors = 0, checked = 0, i;
    always #2.5 pclk = ~pclk;
    aese_engine uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .dma_wr_en(dma_wr_en), .dma_wr_data(dma_wr_data),
        .dma_rd_en(dma_rd_en), .dma_rd_data(dma_rd_data),
        .dma_in_req(dma_in_req), .dma_out_req(dma_out_req));
    aese_dma_model u_dma (.pclk(pclk), .go(go), .blk(P),
        .dma_in_req(dma_in_req), .dma_out_req(dma_out_req),
        .dma_rd_data(dma_rd_data), .dma_wr_en(dma_wr_en),
        .dma_wr_data(dma_wr_data), .dma_rd_en(dma_rd_en),
        .result(result), .done(done));
    // ==========================================
    // helpers: one apb transfer, one compare
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task complete_run;
        if (num_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================
    // scenario: one processor-driven block with flag and irq checks
    task run_block(input logic [7:0] c, input logic [127:0] din,
        input logic [127:0] exp, input logic ei);
        apb(1'b1, A_CTRL, {24'h0, c | 8'h06});
        apb(1'b0, A_CTRL, 32'h0);
        chk(rd, {24'h0, c | 8'h02});
        for (i = 0; i < 4; i++) apb(1'b1, A_WIN + 4 * i, din[32*i +: 32]);
        apb(1'b0, A_CTRL, 32'h0);
        chk(rd, {24'h0, c});
        do apb(1'b0, A_CTRL, 32'h0); while (rd[2] !== 1'b1);
        chk(irq, ei);
        for (i = 0; i < 4; i++)
        begin
            apb(1'b0, A_WIN + 4 * i, 32'h0);
            chk(rd, exp[32*i +: 32]);
        end
        apb(1'b0, A_CTRL, 32'h0);
        chk(rd, {24'h0, c | 8'h02});
    endtask
    // ==========================================
    // scenario: reset values, refused accesses, key load and readback
    task check_reset_and_key;
        apb(1'b0, A_CTRL, 32'h0);
        chk(rd, {24'h0, `AESE_CTRL_RESET});
        chk(irq, 1'b0);
        apb(1'b0, A_CTRL + 16'h2, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        // no result yet: window reads zero and must not count
        apb(1'b0, A_WIN, 32'h0);
        chk(rd, 32'h0);
        for (i = 0; i < 16; i++)
            apb(1'b1, A_KEY + 4 * i, K[127-8*i -: 8]);
        apb(1'b0, A_KEY + 16'h3C, 32'h0);
        chk(rd, {24'h0, K[7:0]});
    endtask
    // ==========================================
    // scenario: done interrupt, status readback, write-one-to-clear
    task run_irq;
        apb(1'b1, A_STAT, 32'h3);
        apb(1'b1, A_MASK, 32'h1);
        // irq follows the registers on the edge that ends the write; the check waits one more
        @(posedge pclk);
        chk(irq, 1'b0);
        run_block(8'h00, P, C, 1'b1);
        apb(1'b0, A_STAT, 32'h0);
        chk(rd, 32'h3);
        apb(1'b1, A_STAT, 32'h3);
        @(posedge pclk);
        chk(irq, 1'b0);
        apb(1'b1, A_MASK, 32'h0);
    endtask
    // ==========================================
    // scenario: dma moves one block in and the result out
    task run_dma;
        apb(1'b1, A_CTRL, 32'h0);
        go <= 1'b1;
        while (done !== 1'b1) @(posedge pclk);
        for (i = 0; i < 4; i++)
            chk(result[32*i +: 32], C[32*i +: 32]);
    endtask
    initial
    begin
        #(5 * 20000);
        num_errors++;
        complete_run();
    end
    // ==========================================
    // main sequence
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        check_reset_and_key();
        run_block(8'h00, P, C, 1'b0);
        run_block(8'h01, C, P, 1'b0);
        run_irq();
        // chaining from a cleared previous result, then fed back
        run_block(8'h80, P, C, 1'b0);
        run_block(8'h80, P ^ C, C, 1'b0);
        // decrypt side of the chain: plain result xor previous result
        run_block(8'h81, C, P ^ C, 1'b0);
        run_dma();
        complete_run();
    end
endmodule
